/* pkg/lcsgp_pkg.sv */
package lcsgp_pkg;

  // register indices as printed; the byte address is four times the index
  localparam logic [7:0] LCSGP_IDX_LINE_STATUS = 8'h02;
  localparam logic [7:0] LCSGP_IDX_PEAK_LOW    = 8'h18;
  localparam logic [7:0] LCSGP_IDX_PEAK_HIGH   = 8'h19;
  localparam logic [7:0] LCSGP_IDX_RX_GAIN     = 8'h20;
  localparam logic [7:0] LCSGP_IDX_IRQ_STATUS  = 8'h28;
  localparam logic [7:0] LCSGP_IDX_IRQ_MASK    = 8'h29;
  localparam int         LCSGP_IDX_SHIFT       = 2;
  localparam int         LCSGP_ADDR_BITS       = 10;

  // line canceller status bit positions
  localparam int LCSGP_LS_RX_NB  = 0;
  localparam int LCSGP_LS_ANY_NB = 1;
  localparam int LCSGP_LS_DT     = 2;
  localparam int LCSGP_LS_NLP    = 3;
  // send-path narrowband bit inside the acoustic canceller status
  localparam int LCSGP_AS_TX_NB  = 0;

  // interrupt status and mask bit positions
  localparam int LCSGP_IRQ_RX_NB = 0;
  localparam int LCSGP_IRQ_DT    = 1;
  localparam int LCSGP_IRQ_NLP   = 2;
  localparam int LCSGP_IRQ_PEAK  = 3;
  localparam int LCSGP_IRQ_BITS  = 4;

  // reset values
  localparam logic [7:0]  LCSGP_RST_LINE_STATUS = 8'h00;
  localparam logic [7:0]  LCSGP_RST_PEAK_BYTE   = 8'h00;
  localparam logic [7:0]  LCSGP_RST_RX_GAIN     = 8'h6d;
  localparam logic [3:0]  LCSGP_RST_IRQ         = 4'h0;

  // gain code field
  localparam int LCSGP_GAIN_LSB   = 0;
  localparam int LCSGP_GAIN_MSB   = 3;
  localparam int LCSGP_GAIN_FRAC  = 12;

  // gain factors in unsigned q4.12, code 0h = -24 dB up to code fh = +21 dB, 3 dB steps
  localparam logic [15:0] LCSGP_GAIN_Q12 [16] = '{
    16'h0102, 16'h016d, 16'h0204, 16'h02d8,
    16'h0405, 16'h05ad, 16'h0805, 16'h0b54,
    16'h1000, 16'h169a, 16'h1fed, 16'h2d18,
    16'h3fb2, 16'h59fa, 16'h7f18, 16'hb386
  };

  // axi4-lite responses
  localparam logic [1:0] LCSGP_RESP_OKAY   = 2'b00;
  localparam logic [1:0] LCSGP_RESP_SLVERR = 2'b10;
  localparam logic [1:0] LCSGP_RESP_DECERR = 2'b11;

endpackage : lcsgp_pkg

/* hw/lcsgp_rx_gain.sv */
module lcsgp_rx_gain
  import lcsgp_pkg::*;
#(
  parameter int SAMPLE_WIDTH = 16
) (
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic [3:0]                     gain_code,
  input  wire logic signed [SAMPLE_WIDTH-1:0] sample_in,
  input  wire logic                           sample_in_valid,
  output logic signed [SAMPLE_WIDTH-1:0]      sample_out,
  output logic                                sample_out_valid
);

  localparam int PROD_W = SAMPLE_WIDTH + 17;

  if (SAMPLE_WIDTH < 2) begin : g_bad_width
    $error("lcsgp_rx_gain: SAMPLE_WIDTH too small");
  end

  localparam logic signed [SAMPLE_WIDTH-1:0] MAX_S = {1'b0, {(SAMPLE_WIDTH-1){1'b1}}};
  localparam logic signed [SAMPLE_WIDTH-1:0] MIN_S = {1'b1, {(SAMPLE_WIDTH-1){1'b0}}};

  wire logic signed [16:0]       factor   = $signed({1'b0, LCSGP_GAIN_Q12[gain_code]});
  wire logic signed [PROD_W-1:0] product  = PROD_W'(sample_in * factor);
  wire logic signed [PROD_W-1:0] scaled   = product >>> LCSGP_GAIN_FRAC;
  wire logic                     too_high = scaled > PROD_W'(MAX_S);
  wire logic                     too_low  = scaled < PROD_W'(MIN_S);
  // saturate rather than wrap: a wrapped loud sample turns into a full-scale click
  wire logic signed [SAMPLE_WIDTH-1:0] clipped =
    too_high ? MAX_S : (too_low ? MIN_S : scaled[SAMPLE_WIDTH-1:0]);

  logic signed [SAMPLE_WIDTH-1:0] sample_out_reg;
  logic                           sample_out_valid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_out_reg       <= '0;
      sample_out_valid_reg <= 1'b0;
    end else begin
      sample_out_valid_reg <= sample_in_valid;
      if (sample_in_valid) begin
        sample_out_reg <= clipped;
      end
    end
  end

  assign sample_out       = sample_out_reg;
  assign sample_out_valid = sample_out_valid_reg;

endmodule : lcsgp_rx_gain

/* hw/lcsgp_regs.sv */
module lcsgp_regs
  import lcsgp_pkg::*;
#(
  parameter int PEAK_WIDTH   = 16,
  parameter int SAMPLE_WIDTH = 16
) (
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  // axi4-lite slave
  input  wire logic [LCSGP_ADDR_BITS-1:0]     s_axi_awaddr,
  input  wire logic [2:0]                     s_axi_awprot,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  input  wire logic [LCSGP_ADDR_BITS-1:0]     s_axi_araddr,
  input  wire logic [2:0]                     s_axi_arprot,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [31:0]                         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  // datapath status
  input  wire logic                           rx_narrowband_flag,
  input  wire logic [7:0]                     acoustic_canceller_status,
  input  wire logic                           double_talk_flag,
  input  wire logic                           line_nonlinear_active,
  // receive error peak from the detector after echo subtraction
  input  wire logic [PEAK_WIDTH-1:0]          rx_error_peak,
  input  wire logic                           rx_error_peak_valid,
  // receive path samples through the user gain
  input  wire logic signed [SAMPLE_WIDTH-1:0] rx_sample_in,
  input  wire logic                           rx_sample_in_valid,
  output logic signed [SAMPLE_WIDTH-1:0]      rx_sample_out,
  output logic                                rx_sample_out_valid,
  output logic [3:0]                          rx_gain_code,
  output logic                                irq
);

  if (PEAK_WIDTH != 16) begin : g_bad_peak
    $error("lcsgp_regs: the peak is split over exactly two byte registers");
  end

  // ---------------------------------------------------------------- decode
  wire logic [7:0] ar_idx = s_axi_araddr[LCSGP_IDX_SHIFT +: 8];
  wire logic       ar_top_ok = (s_axi_araddr[LCSGP_ADDR_BITS-1:LCSGP_IDX_SHIFT] >> 8) == '0;

  logic [LCSGP_ADDR_BITS-1:0] aw_addr_reg;
  logic [31:0]                w_data_reg;
  logic [3:0]                 w_strb_reg;
  logic                       aw_full_reg;
  logic                       w_full_reg;
  logic                       awready_reg;
  logic                       wready_reg;
  logic                       bvalid_reg;
  logic [1:0]                 bresp_reg;
  logic                       arready_reg;
  logic                       rvalid_reg;
  logic [31:0]                rdata_reg;
  logic [1:0]                 rresp_reg;

  wire logic [7:0] wr_idx    = aw_addr_reg[LCSGP_IDX_SHIFT +: 8];
  wire logic       wr_top_ok =
    (aw_addr_reg[LCSGP_ADDR_BITS-1:LCSGP_IDX_SHIFT] >> 8) == '0;
  wire logic       aw_take   = s_axi_awvalid & awready_reg;
  wire logic       w_take    = s_axi_wvalid & wready_reg;
  wire logic       wr_fire   = aw_full_reg & w_full_reg & ~bvalid_reg;
  wire logic       ar_take   = s_axi_arvalid & arready_reg;

  wire logic wr_gain   = wr_fire & wr_top_ok & (wr_idx == LCSGP_IDX_RX_GAIN);
  wire logic wr_istat  = wr_fire & wr_top_ok & (wr_idx == LCSGP_IDX_IRQ_STATUS);
  wire logic wr_imask  = wr_fire & wr_top_ok & (wr_idx == LCSGP_IDX_IRQ_MASK);
  wire logic wr_ro     = wr_top_ok & ((wr_idx == LCSGP_IDX_LINE_STATUS) |
                                      (wr_idx == LCSGP_IDX_PEAK_LOW) |
                                      (wr_idx == LCSGP_IDX_PEAK_HIGH));
  wire logic wr_rw     = wr_top_ok & ((wr_idx == LCSGP_IDX_RX_GAIN) |
                                      (wr_idx == LCSGP_IDX_IRQ_STATUS) |
                                      (wr_idx == LCSGP_IDX_IRQ_MASK));
  // a write to a read-only register is dropped and answered with an error
  wire logic [1:0] wr_resp = wr_rw ? LCSGP_RESP_OKAY :
                             (wr_ro ? LCSGP_RESP_SLVERR : LCSGP_RESP_DECERR);
  wire logic       lane0   = w_strb_reg[0];

  // ---------------------------------------------------------------- state
  logic [7:0]                line_status_reg;
  logic [7:0]                rx_user_gain_reg;
  logic [PEAK_WIDTH-1:0]     peak_reg;
  logic [7:0]                peak_high_shadow_reg;
  logic [LCSGP_IRQ_BITS-1:0] irq_status_reg;
  logic [LCSGP_IRQ_BITS-1:0] irq_mask_reg;
  logic                      irq_reg;

  wire logic tx_narrowband_flag  = acoustic_canceller_status[LCSGP_AS_TX_NB];
  wire logic any_narrowband_flag = rx_narrowband_flag | tx_narrowband_flag;

  logic [7:0] line_status_next;
  always_comb begin
    line_status_next                  = LCSGP_RST_LINE_STATUS;
    line_status_next[LCSGP_LS_RX_NB]  = rx_narrowband_flag;
    line_status_next[LCSGP_LS_ANY_NB] = any_narrowband_flag;
    line_status_next[LCSGP_LS_DT]     = double_talk_flag;
    line_status_next[LCSGP_LS_NLP]    = line_nonlinear_active;
  end

  // events: rising edges of the receive narrowband, double-talk and nonlinear flags, and every new peak sample
  logic [LCSGP_IRQ_BITS-1:0] irq_event;
  always_comb begin
    irq_event                  = '0;
    irq_event[LCSGP_IRQ_RX_NB] = rx_narrowband_flag & ~line_status_reg[LCSGP_LS_RX_NB];
    irq_event[LCSGP_IRQ_DT]    = double_talk_flag & ~line_status_reg[LCSGP_LS_DT];
    irq_event[LCSGP_IRQ_NLP]   = line_nonlinear_active & ~line_status_reg[LCSGP_LS_NLP];
    irq_event[LCSGP_IRQ_PEAK]  = rx_error_peak_valid;
  end

  wire logic [7:0] wdata_b0 = w_data_reg[7:0];
  wire logic [LCSGP_IRQ_BITS-1:0] irq_clear =
    (wr_istat & lane0) ? wdata_b0[LCSGP_IRQ_BITS-1:0] : '0;
  // the set term comes last so an event in the clearing cycle survives
  wire logic [LCSGP_IRQ_BITS-1:0] irq_status_next = (irq_status_reg & ~irq_clear) | irq_event;
  wire logic [LCSGP_IRQ_BITS-1:0] irq_mask_next   =
    (wr_imask & lane0) ? wdata_b0[LCSGP_IRQ_BITS-1:0] : irq_mask_reg;

  // ---------------------------------------------------------------- read mux
  wire logic rd_peak_low = ar_top_ok & (ar_idx == LCSGP_IDX_PEAK_LOW);
  logic [31:0] rd_data;
  logic [1:0]  rd_resp;
  always_comb begin
    rd_data = '0;
    rd_resp = LCSGP_RESP_OKAY;
    if (!ar_top_ok) begin
      rd_resp = LCSGP_RESP_DECERR;
    end else begin
      unique case (ar_idx)
        LCSGP_IDX_LINE_STATUS: rd_data[7:0] = line_status_reg;
        LCSGP_IDX_PEAK_LOW:    rd_data[7:0] = peak_reg[7:0];
        LCSGP_IDX_PEAK_HIGH:   rd_data[7:0] = peak_high_shadow_reg;
        LCSGP_IDX_RX_GAIN:     rd_data[7:0] = rx_user_gain_reg;
        LCSGP_IDX_IRQ_STATUS:  rd_data[LCSGP_IRQ_BITS-1:0] = irq_status_reg;
        LCSGP_IDX_IRQ_MASK:    rd_data[LCSGP_IRQ_BITS-1:0] = irq_mask_reg;
        default:               rd_resp = LCSGP_RESP_DECERR;
      endcase
    end
  end

  // ---------------------------------------------------------------- bus handshakes
  wire logic aw_full_next = aw_full_reg ? ~wr_fire : aw_take;
  wire logic w_full_next  = w_full_reg ? ~wr_fire : w_take;
  wire logic bvalid_next  = wr_fire | (bvalid_reg & ~s_axi_bready);
  wire logic rvalid_next  = ar_take | (rvalid_reg & ~s_axi_rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      awready_reg <= ~aw_full_next;
      wready_reg  <= ~w_full_next;
      bvalid_reg  <= bvalid_next;
      arready_reg <= ~rvalid_next;
      rvalid_reg  <= rvalid_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      bresp_reg   <= LCSGP_RESP_OKAY;
      rdata_reg   <= '0;
      rresp_reg   <= LCSGP_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bresp_reg <= wr_resp;
      end
      if (ar_take) begin
        rdata_reg <= rd_data;
        rresp_reg <= rd_resp;
      end
    end
  end

  // ---------------------------------------------------------------- registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_status_reg  <= LCSGP_RST_LINE_STATUS;
      rx_user_gain_reg <= LCSGP_RST_RX_GAIN;
      irq_status_reg   <= LCSGP_RST_IRQ;
      irq_mask_reg     <= LCSGP_RST_IRQ;
      irq_reg          <= 1'b0;
    end else begin
      line_status_reg <= line_status_next;
      if (wr_gain && lane0) begin
        rx_user_gain_reg <= wdata_b0;
      end
      irq_status_reg <= irq_status_next;
      irq_mask_reg   <= irq_mask_next;
      irq_reg        <= |(irq_status_next & irq_mask_next);
    end
  end

  // the high byte is frozen when the low byte is read, so a new peak landing
  // between the two reads cannot tear the value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      peak_reg             <= {LCSGP_RST_PEAK_BYTE, LCSGP_RST_PEAK_BYTE};
      peak_high_shadow_reg <= LCSGP_RST_PEAK_BYTE;
    end else begin
      if (rx_error_peak_valid) begin
        peak_reg <= rx_error_peak;
      end
      if (ar_take && rd_peak_low) begin
        peak_high_shadow_reg <= peak_reg[15:8];
      end
    end
  end

  // ---------------------------------------------------------------- receive gain
  lcsgp_rx_gain #(
    .SAMPLE_WIDTH (SAMPLE_WIDTH)
  ) u_rx_gain (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .gain_code        (rx_user_gain_reg[LCSGP_GAIN_MSB:LCSGP_GAIN_LSB]),
    .sample_in        (rx_sample_in),
    .sample_in_valid  (rx_sample_in_valid),
    .sample_out       (rx_sample_out),
    .sample_out_valid (rx_sample_out_valid)
  );

  assign rx_gain_code  = rx_user_gain_reg[LCSGP_GAIN_MSB:LCSGP_GAIN_LSB];
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign irq           = irq_reg;

endmodule : lcsgp_regs

/* test/lcsgp_regs_properties.sv */
module lcsgp_regs_properties #(
  parameter int SAMPLE_WIDTH = 16
) (
  input wire logic                           aclk,
  input wire logic                           aresetn,
  input wire logic                           s_axi_arready,
  input wire logic [31:0]                    s_axi_rdata,
  input wire logic                           s_axi_rvalid,
  input wire logic                           s_axi_rready,
  input wire logic [1:0]                     s_axi_bresp,
  input wire logic                           s_axi_bvalid,
  input wire logic                           s_axi_bready,
  input wire logic signed [SAMPLE_WIDTH-1:0] rx_sample_in,
  input wire logic                           rx_sample_in_valid,
  input wire logic signed [SAMPLE_WIDTH-1:0] rx_sample_out,
  input wire logic                           rx_sample_out_valid,
  input wire logic [3:0]                     rx_gain_code,
  input wire logic                           irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_values: assert property ($rose(aresetn) |-> rx_gain_code == 4'hd && !irq)
    else $error("gain code or irq wrong after reset");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data changed while waiting");
  a_byte_regs: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted");
  a_gain_latency: assert property (rx_sample_in_valid |=> rx_sample_out_valid)
    else $error("gained sample late");
  a_unity_gain: assert property (rx_sample_in_valid && rx_gain_code == 4'h8 |=>
    rx_sample_out == $past(rx_sample_in)) else $error("code 8 not unity");
  a_min_gain: assert property (rx_sample_in_valid && rx_gain_code == 4'h0 &&
    rx_sample_in == 16'sh0400 |=> rx_sample_out == 16'sh0040) else $error("code 0 not -24 dB");
endmodule : lcsgp_regs_properties

/* test/lcsgp_host_model.sv */
module lcsgp_host_model
  import lcsgp_pkg::*;
(
  input  wire logic                       aclk,
  output logic [LCSGP_ADDR_BITS-1:0]      s_axi_awaddr,
  output logic [2:0]                      s_axi_awprot,
  output logic                            s_axi_awvalid,
  input  wire logic                       s_axi_awready,
  output logic [31:0]                     s_axi_wdata,
  output logic [3:0]                      s_axi_wstrb,
  output logic                            s_axi_wvalid,
  input  wire logic                       s_axi_wready,
  input  wire logic [1:0]                 s_axi_bresp,
  input  wire logic                       s_axi_bvalid,
  output logic                            s_axi_bready,
  output logic [LCSGP_ADDR_BITS-1:0]      s_axi_araddr,
  output logic [2:0]                      s_axi_arprot,
  output logic                            s_axi_arvalid,
  input  wire logic                       s_axi_arready,
  input  wire logic [31:0]                s_axi_rdata,
  input  wire logic [1:0]                 s_axi_rresp,
  input  wire logic                       s_axi_rvalid,
  output logic                            s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arprot, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'h1;
  end
  // released payload is inverted so a stale value cannot pass for a live one
  task automatic wr(input logic [9:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    // a late ready makes the slave hold its answer for a cycle
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : lcsgp_host_model

/* test/line_canceller_status_gain_peak_regs_tb.sv */
module line_canceller_status_gain_peak_regs_tb;
  import lcsgp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [9:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, rx_gain_code;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic rx_narrowband_flag, double_talk_flag, line_nonlinear_active, rx_error_peak_valid;
  logic [7:0] acoustic_canceller_status;
  logic [15:0] rx_error_peak;
  logic signed [15:0] rx_sample_in, rx_sample_out;
  logic rx_sample_in_valid, rx_sample_out_valid, irq;
  int errors;
  int compares;
  logic [31:0] d;
  logic [1:0] r;

  lcsgp_regs lcsgp_regs_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_narrowband_flag,
    .acoustic_canceller_status, .double_talk_flag, .line_nonlinear_active, .rx_error_peak,
    .rx_error_peak_valid, .rx_sample_in, .rx_sample_in_valid, .rx_sample_out,
    .rx_sample_out_valid, .rx_gain_code, .irq);
  lcsgp_host_model lcsgp_host_model_i (.aclk, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic rd_chk(input logic [9:0] a, input logic [31:0] e, input logic [1:0] er);
    lcsgp_host_model_i.rd(a, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask : rd_chk

  task automatic wr_chk(input logic [9:0] a, input logic [31:0] v, input logic [1:0] er);
    lcsgp_host_model_i.wr(a, v, r);
    chk({30'h0, r}, {30'h0, er});
  endtask : wr_chk

  task automatic t_reset;
    rd_chk(10'h080, 32'h6d, LCSGP_RESP_OKAY);
    rd_chk(10'h008, 32'h00, LCSGP_RESP_OKAY);
    rd_chk(10'h060, 32'h00, LCSGP_RESP_OKAY);
  endtask : t_reset

  // upper status bits are held at 5a, only the send narrowband bit may reach the line status
  task automatic t_status;
    for (int i = 0; i < 16; i++) begin
      rx_narrowband_flag <= i[0];
      acoustic_canceller_status <= {7'h5a, i[1]};
      double_talk_flag <= i[2];
      line_nonlinear_active <= i[3];
      repeat (2) @(posedge aclk);
      rd_chk(10'h008, {28'h0, i[3:2], |i[1:0], i[0]}, LCSGP_RESP_OKAY);
    end
  endtask : t_status

  task automatic t_refuse;
    wr_chk(10'h008, 32'h00, LCSGP_RESP_SLVERR);
    rd_chk(10'h008, 32'h0f, LCSGP_RESP_OKAY);
    wr_chk(10'h064, 32'hff, LCSGP_RESP_SLVERR);
    wr_chk(10'h3fc, 32'h6d, LCSGP_RESP_DECERR);
    rd_chk(10'h3fc, 32'h00, LCSGP_RESP_DECERR);
  endtask : t_refuse

  // unit-level sample of 1024 lands on the gain factor divided by four
  task automatic t_gain;
    for (int c = 0; c < 16; c++) begin
      wr_chk(10'h080, {24'h0, 4'ha, c[3:0]}, LCSGP_RESP_OKAY);
      rd_chk(10'h080, {24'h0, 4'ha, c[3:0]}, LCSGP_RESP_OKAY);
      chk({28'h0, rx_gain_code}, c);
      rx_sample_in <= 16'sh0400;
      rx_sample_in_valid <= 1'b1;
      @(posedge aclk);
      rx_sample_in_valid <= 1'b0;
      @(posedge aclk);
      chk({16'h0, rx_sample_out}, {16'h0, LCSGP_GAIN_Q12[c] >> 2});
    end
  endtask : t_gain

  task automatic pulse_peak(input logic [15:0] v);
    @(posedge aclk);
    rx_error_peak <= v;
    rx_error_peak_valid <= 1'b1;
    @(posedge aclk);
    rx_error_peak_valid <= 1'b0;
  endtask : pulse_peak

  task automatic t_peak;
    wr_chk(10'h0a0, 32'h0f, LCSGP_RESP_OKAY);
    rd_chk(10'h0a0, 32'h00, LCSGP_RESP_OKAY);
    pulse_peak(16'hc3a5);
    rd_chk(10'h060, 32'ha5, LCSGP_RESP_OKAY);
    pulse_peak(16'h1234);
    rd_chk(10'h064, 32'hc3, LCSGP_RESP_OKAY);
    rd_chk(10'h060, 32'h34, LCSGP_RESP_OKAY);
    rd_chk(10'h064, 32'h12, LCSGP_RESP_OKAY);
    rd_chk(10'h0a0, 32'h08, LCSGP_RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    wr_chk(10'h0a4, 32'h08, LCSGP_RESP_OKAY);
    @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    wr_chk(10'h0a0, 32'h08, LCSGP_RESP_OKAY);
    @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
  endtask : t_peak

  task automatic tally_and_finish;
    if (errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  initial begin
    aresetn = 1'b0;
    {rx_narrowband_flag, double_talk_flag, line_nonlinear_active, rx_error_peak_valid} = '0;
    acoustic_canceller_status = 8'h00;
    rx_error_peak = 16'h0000;
    rx_sample_in = 16'sh0000;
    rx_sample_in_valid = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_status();
    t_refuse();
    t_gain();
    t_peak();
    tally_and_finish();
  end

  // about 300 cycles of traffic expected; twenty times that means a hang
  initial begin
    repeat (6000) @(posedge aclk);
    errors++;
    tally_and_finish();
  end
endmodule : line_canceller_status_gain_peak_regs_tb

bind lcsgp_regs lcsgp_regs_properties #(.SAMPLE_WIDTH(SAMPLE_WIDTH)) lcsgp_regs_properties_i (
  .aclk, .aresetn, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .rx_sample_in, .rx_sample_in_valid, .rx_sample_out,
  .rx_sample_out_valid, .rx_gain_code, .irq);
